// ===== common/sacs_regs.svh
// Register offsets, reset values and timing counts of the conversion sequencer
`ifndef SACS_REGS_SVH
`define SACS_REGS_SVH

// ****************************************
// Register word offsets
// ****************************************
`define SACS_OFS_CTL0 6'h00
`define SACS_OFS_CTL1 6'h01
`define SACS_OFS_FLAGS 6'h02
`define SACS_OFS_STAT 6'h03
`define SACS_OFS_PINSEL 6'h04
`define SACS_OFS_MCTL_BASE 2'h1
`define SACS_OFS_MEM_BASE 2'h2

// ****************************************
// Field positions
// ****************************************
`define SACS_CTL0_ARM_BIT 0
`define SACS_CTL0_SC_BIT 1
`define SACS_STAT_BUSY_BIT 0
`define SACS_STAT_ROVR_BIT 1
`define SACS_STAT_TOVR_BIT 2

// ****************************************
// Reset values
// ****************************************
`define SACS_RST_CTL0 16'h0000
`define SACS_RST_CTL1 16'h0000
`define SACS_RST_MCTL 8'h00
`define SACS_RST_PINSEL 8'h00

// ****************************************
// Timing counts, in conversion clocks, and the full-scale result code
// ****************************************
`define SACS_CONV_CYCLES 4'd13
`define SACS_LAST_CONV_CNT 4'd12
`define SACS_FULL_SCALE 12'h0FFF

`endif

// ===== common/sacs_pkg.sv
// Types shared by the conversion sequencer
package sacs_pkg;

    typedef enum logic [1:0] {
        SACS_IDLE = 2'b00,
        SACS_WAIT = 2'b01,
        SACS_SAMPLE = 2'b10,
        SACS_CONV = 2'b11
    } sacs_state_t;

    typedef struct packed {
        logic [3:0] sht_high;
        logic [3:0] sht_low;
        logic [1:0] rsv;
        logic multiple_sample_convert;
        logic core_on;
        logic ref_high;
        logic ref_on;
        logic sc;
        logic arm;
    } sacs_ctl0_t;

    typedef struct packed {
        logic [3:0] start_idx;
        logic rsv;
        logic [1:0] shs;
        logic trigger_polarity_invert;
        logic sample_pulse_mode_sel;
        logic [2:0] div;
        logic [1:0] ssel;
        logic [1:0] mode;
    } sacs_ctl1_t;

    typedef struct packed {
        logic end_of_sequence_mark;
        logic [2:0] sref;
        logic [3:0] inch;
    } sacs_mctl_t;

endpackage

// ===== src/sacs_sequencer.sv
// Conversion sequencer around a 12-bit successive-approximation core
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "sacs_regs.svh"

module sacs_sequencer
    import sacs_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [5:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic SUBSYS_CLK_I,
    input wire logic MASTER_CLK_I,
    input wire logic AUX_CLK_I,
    input wire logic OSC_CLK_I,
    input wire logic [2:0] TMR_TRIG_I,
    input wire logic COMP_I,
    output logic [11:0] DAC_O,
    output logic SAMPLE_O,
    output logic [3:0] CHAN_SEL_O,
    output logic [2:0] REF_SEL_O,
    output logic CORE_EN_O,
    output logic OSC_EN_O,
    output logic REF_EN_O,
    output logic REF_HIGH_O,
    output logic [7:0] PIN_ANALOG_O,
    output logic BUSY_O
);

    // ****************************************
    // Register file
    // ****************************************
    sacs_ctl0_t ctl0_q;
    sacs_ctl1_t ctl1_q;
    sacs_mctl_t mctl_q [16];
    logic [11:0] mem_q [16];
    logic [15:0] ifg_q;
    logic [7:0] pinsel_q;
    logic rovr_q;
    logic tovr_q;
    logic [15:0] rdata_q;

    sacs_state_t st_q;
    sacs_state_t st_d;
    logic [3:0] ptr_q;
    logic [3:0] ptr_d;
    logic res_wr;
    logic conv_start;
    logic [11:0] sar_q;

    logic wr_ctl0;
    logic wr_ctl1;
    logic wr_mctl;
    logic rd_mem;
    assign wr_ctl0 = WR_I && ADDR_I == `SACS_OFS_CTL0;
    assign wr_ctl1 = WR_I && ADDR_I == `SACS_OFS_CTL1;
    assign wr_mctl = WR_I && ADDR_I[5:4] == `SACS_OFS_MCTL_BASE;
    assign rd_mem = RD_I && ADDR_I[5:4] == `SACS_OFS_MEM_BASE;

    // Arm and start bits stay writable while armed so software can disarm
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctl0_q <= `SACS_RST_CTL0;
        end else begin
            if (wr_ctl0) begin
                if (!ctl0_q.arm) begin
                    ctl0_q <= WDATA_I;
                end else begin
                    ctl0_q.arm <= WDATA_I[`SACS_CTL0_ARM_BIT];
                    ctl0_q.sc <= WDATA_I[`SACS_CTL0_SC_BIT];
                end
            end else if (conv_start) begin
                ctl0_q.sc <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctl1_q <= `SACS_RST_CTL1;
        end else if (wr_ctl1 && !ctl0_q.arm) begin
            ctl1_q <= WDATA_I;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_mctl
            always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    mctl_q[gi] <= `SACS_RST_MCTL;
                end else if (wr_mctl && ADDR_I[3:0] == gi && !ctl0_q.arm) begin
                    mctl_q[gi] <= WDATA_I[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pinsel_q <= `SACS_RST_PINSEL;
        end else if (WR_I && ADDR_I == `SACS_OFS_PINSEL) begin
            pinsel_q <= WDATA_I[7:0];
        end
    end

    // Result memory has no reset; flags say which slots hold data
    always_ff @(posedge SYS_CLK_I) begin
        if (res_wr) begin
            mem_q[ptr_q] <= sar_q;
        end
    end

    // Hardware set wins over a software or read clear
    logic [15:0] ifg_d;
    always_comb begin
        ifg_d = ifg_q;
        if (WR_I && ADDR_I == `SACS_OFS_FLAGS) begin
            ifg_d = WDATA_I;
        end
        if (rd_mem) begin
            ifg_d[ADDR_I[3:0]] = 1'b0;
        end
        if (res_wr) begin
            ifg_d[ptr_q] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ifg_q <= 16'h0000;
        end else begin
            ifg_q <= ifg_d;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 16'h0000;
        end else if (RD_I) begin
            unique case (ADDR_I[5:4])
                2'h0: begin
                    unique case (ADDR_I)
                        `SACS_OFS_CTL0: rdata_q <= ctl0_q;
                        `SACS_OFS_CTL1: rdata_q <= ctl1_q;
                        `SACS_OFS_FLAGS: rdata_q <= ifg_q;
                        `SACS_OFS_STAT: rdata_q <= {13'h0000, tovr_q, rovr_q, BUSY_O};
                        `SACS_OFS_PINSEL: rdata_q <= {8'h00, pinsel_q};
                        default: rdata_q <= 16'h0000;
                    endcase
                end
                2'h1: rdata_q <= {8'h00, mctl_q[ADDR_I[3:0]]};
                2'h2: rdata_q <= {4'h0, mem_q[ADDR_I[3:0]]};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign RDATA_O = rdata_q;

    // ****************************************
    // Conversion clock
    // ****************************************
    logic [3:0] clk_vec;
    logic src_q;
    logic [2:0] div_cnt_q;
    logic tick;
    assign clk_vec = {OSC_CLK_I, AUX_CLK_I, MASTER_CLK_I, SUBSYS_CLK_I};
    assign tick = clk_vec[ctl1_q.ssel] && !src_q && div_cnt_q == ctl1_q.div;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            src_q <= 1'b0;
            div_cnt_q <= 3'd0;
        end else begin
            src_q <= clk_vec[ctl1_q.ssel];
            if (tick) begin
                div_cnt_q <= 3'd0;
            end else if (clk_vec[ctl1_q.ssel] && !src_q) begin
                div_cnt_q <= div_cnt_q + 3'd1;
            end
        end
    end

    // ****************************************
    // Trigger path
    // ****************************************
    logic [3:0] trig_vec;
    logic sample_hold_input;
    logic shi_q;
    logic shi_rise;
    logic chain;
    assign trig_vec = {TMR_TRIG_I, ctl0_q.sc};
    assign sample_hold_input = trig_vec[ctl1_q.shs] ^ ctl1_q.trigger_polarity_invert;
    assign shi_rise = sample_hold_input && !shi_q;
    assign chain = ctl0_q.multiple_sample_convert && ctl1_q.sample_pulse_mode_sel && ctl1_q.mode != 2'b00;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            shi_q <= 1'b0;
        end else begin
            shi_q <= sample_hold_input;
        end
    end

    // ****************************************
    // Sampling timer
    // ****************************************
    sacs_mctl_t cur;
    logic [3:0] sht;
    logic [6:0] samp_len;
    logic [6:0] samp_cnt_q;
    logic synced_q;
    logic samp_done;
    assign cur = mctl_q[ptr_q];
    assign sht = ptr_q[3] ? ctl0_q.sht_high : ctl0_q.sht_low;
    assign samp_len = {({1'b0, sht} + 5'd1), 2'b00};
    assign samp_done = tick && synced_q && samp_cnt_q == samp_len - 7'd1;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            synced_q <= 1'b0;
            samp_cnt_q <= 7'd0;
        end else if (st_q != SACS_SAMPLE) begin
            synced_q <= 1'b0;
            samp_cnt_q <= 7'd0;
        end else if (tick) begin
            if (!synced_q) begin
                synced_q <= 1'b1;
            end else begin
                samp_cnt_q <= samp_cnt_q + 7'd1;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    logic [3:0] cnt_q;
    sacs_state_t cont;
    assign cont = chain ? SACS_SAMPLE : SACS_WAIT;

    always_comb begin
        st_d = st_q;
        ptr_d = ptr_q;
        res_wr = 1'b0;
        unique case (st_q)
            SACS_IDLE: begin
                if (ctl0_q.arm && shi_rise) begin
                    st_d = SACS_SAMPLE;
                    ptr_d = ctl1_q.start_idx;
                end
            end
            SACS_WAIT: begin
                if (!ctl0_q.arm && !ctl1_q.mode[0]) begin
                    st_d = SACS_IDLE;
                end else if (shi_rise) begin
                    st_d = SACS_SAMPLE;
                end
            end
            SACS_SAMPLE: begin
                if (ctl1_q.sample_pulse_mode_sel ? samp_done : (tick && !sample_hold_input)) begin
                    st_d = SACS_CONV;
                end
            end
            SACS_CONV: begin
                if (tick && cnt_q == `SACS_LAST_CONV_CNT) begin
                    res_wr = 1'b1;
                    unique case (ctl1_q.mode)
                        2'b00: st_d = SACS_IDLE;
                        2'b01: begin
                            if (cur.end_of_sequence_mark) begin
                                st_d = SACS_IDLE;
                            end else begin
                                ptr_d = ptr_q + 4'd1;
                                st_d = cont;
                            end
                        end
                        2'b10: st_d = ctl0_q.arm ? cont : SACS_IDLE;
                        2'b11: begin
                            if (!cur.end_of_sequence_mark) begin
                                ptr_d = ptr_q + 4'd1;
                                st_d = cont;
                            end else if (ctl0_q.arm) begin
                                ptr_d = ctl1_q.start_idx;
                                st_d = cont;
                            end else begin
                                st_d = SACS_IDLE;
                            end
                        end
                    endcase
                end
            end
        endcase
        // Disarm in single-once mode aborts at once; result is unreliable
        if (!ctl0_q.arm && ctl1_q.mode == 2'b00) begin
            st_d = SACS_IDLE;
        end
    end
    assign conv_start = st_q == SACS_SAMPLE && st_d == SACS_CONV;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q <= SACS_IDLE;
            ptr_q <= 4'd0;
        end else begin
            st_q <= st_d;
            ptr_q <= ptr_d;
        end
    end

    // ****************************************
    // Successive approximation
    // ****************************************
    logic [3:0] bitpos;
    assign bitpos = 4'd11 - cnt_q;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_q <= 4'd0;
            sar_q <= 12'h000;
        end else if (conv_start) begin
            cnt_q <= 4'd0;
            sar_q <= 12'h000;
        end else if (st_q == SACS_CONV && tick && cnt_q < `SACS_LAST_CONV_CNT) begin
            sar_q[bitpos] <= COMP_I;
            cnt_q <= cnt_q + 4'd1;
        end
    end

    // ****************************************
    // Overrun flags, write one to clear, set wins
    // ****************************************
    logic stat_wr;
    assign stat_wr = WR_I && ADDR_I == `SACS_OFS_STAT;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rovr_q <= 1'b0;
            tovr_q <= 1'b0;
        end else begin
            if (res_wr && ifg_q[ptr_q]) begin
                rovr_q <= 1'b1;
            end else if (stat_wr && WDATA_I[`SACS_STAT_ROVR_BIT]) begin
                rovr_q <= 1'b0;
            end
            if (shi_rise && (st_q == SACS_SAMPLE || st_q == SACS_CONV) && !chain) begin
                tovr_q <= 1'b1;
            end else if (stat_wr && WDATA_I[`SACS_STAT_TOVR_BIT]) begin
                tovr_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Analog side controls
    // ****************************************
    assign DAC_O = st_q == SACS_CONV ? (sar_q | 12'(12'h001 << bitpos)) : 12'h000;
    assign SAMPLE_O = st_q == SACS_SAMPLE && (ctl1_q.sample_pulse_mode_sel || sample_hold_input);
    assign CHAN_SEL_O = cur.inch;
    assign REF_SEL_O = cur.sref;
    assign BUSY_O = st_q != SACS_IDLE;
    assign CORE_EN_O = ctl0_q.core_on && BUSY_O;
    // Oscillator runs only while busy, and only when chosen as the conversion clock source
    assign OSC_EN_O = ctl1_q.ssel == 2'd3 && BUSY_O;
    assign REF_EN_O = ctl0_q.ref_on;
    assign REF_HIGH_O = ctl0_q.ref_high;
    assign PIN_ANALOG_O = pinsel_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [3:0] conv_ticks_q;
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            conv_ticks_q <= 4'd0;
        end else if (st_q != SACS_CONV) begin
            conv_ticks_q <= 4'd0;
        end else if (tick) begin
            conv_ticks_q <= conv_ticks_q + 4'd1;
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    AST_NO_START_DISARMED: assert property (
        st_q == SACS_IDLE && !ctl0_q.arm |=> st_q == SACS_IDLE)
        else $error("Conversion started while disarmed");
    AST_LOCKED_CTL1: assert property (
        ctl0_q.arm && wr_ctl1 |=> $stable(ctl1_q))
        else $error("Control changed while armed");
    AST_SAR_BIT: assert property (
        st_q == SACS_CONV && tick && cnt_q < 4'd12 |=> sar_q[$past(bitpos)] == $past(COMP_I))
        else $error("Approximation bit not taken from comparator");
    AST_CONV_LEN: assert property (
        res_wr |-> conv_ticks_q == 4'd12 && tick)
        else $error("Conversion not thirteen clocks");
    AST_FLAG_SET: assert property (
        res_wr |=> ifg_q[$past(ptr_q)])
        else $error("Ready flag not set on write");
    AST_CORE_OFF: assert property (
        st_q == SACS_IDLE |-> !CORE_EN_O && !OSC_EN_O)
        else $error("Core powered while idle");
    AST_EXT_SAMPLE: assert property (
        st_q == SACS_SAMPLE && !ctl1_q.sample_pulse_mode_sel |-> SAMPLE_O == (trig_vec[ctl1_q.shs] ^ ctl1_q.trigger_polarity_invert))
        else $error("Extended sampling does not follow trigger");
    AST_SINGLE_SLOT: assert property (
        res_wr && !ctl1_q.mode[0] |-> ptr_q == ctl1_q.start_idx)
        else $error("Single mode used wrong slot");
    AST_WRAP: assert property (
        res_wr && ctl1_q.mode[0] && ptr_q == 4'd15 && !cur.end_of_sequence_mark |=> ptr_q == 4'd0)
        else $error("Sequence did not wrap to slot zero");
    AST_RESULT_OVR: assert property (
        res_wr && ifg_q[ptr_q] |=> rovr_q)
        else $error("Result overrun not flagged");

endmodule
`default_nettype wire

// ===== testbench/sacs_analog_model.sv
// Analog source and comparator model facing the conversion sequencer
`timescale 1ns/10ps
`default_nettype none

module sacs_analog_model (
    input wire logic [11:0] dac_i,
    input wire logic [3:0] chan_i,
    output logic comp_o
);
    // ****************************************
    // Input levels per channel
    // ****************************************
    logic [11:0] level [16];

    initial begin
        for (int i = 0; i < 16; i++) begin
            level[i] = 12'h000;
        end
    end

    // Ideal comparator, so a full-scale input keeps every trial bit
    assign comp_o = (level[chan_i] >= dac_i);
endmodule

`default_nettype wire

// ===== testbench/sacs_sequencer_tb_top.sv
// Self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none

module sacs_sequencer_tb_top;
    import sacs_pkg::*;
    logic sys_clk, rst, wr, rd, comp, saw_core, saw_osc;
    logic [5:0] addr;
    logic [15:0] wdata, rdata, d, exp_flags;
    logic [3:0] src_cnt, chan;
    logic [2:0] tmr, ref_sel;
    logic [11:0] dac;
    logic [31:0] r;
    logic [31:0] seed = 32'hd682_7c16;
    logic sample, busy, core_en, osc_en, ref_en, ref_high;
    logic [7:0] pins;
    int n_fail, checked, cyc, shs;
    int exp_mem [16];

    sacs_sequencer i_dut (
        .SYS_CLK_I(sys_clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .SUBSYS_CLK_I(src_cnt[1]), .MASTER_CLK_I(src_cnt[2]), .AUX_CLK_I(src_cnt[3]),
        .OSC_CLK_I(src_cnt[2]), .TMR_TRIG_I(tmr), .COMP_I(comp), .DAC_O(dac), .SAMPLE_O(sample),
        .CHAN_SEL_O(chan), .REF_SEL_O(ref_sel), .CORE_EN_O(core_en), .OSC_EN_O(osc_en), .REF_EN_O(ref_en),
        .REF_HIGH_O(ref_high), .PIN_ANALOG_O(pins), .BUSY_O(busy)
    );

    sacs_analog_model i_ana (.dac_i(dac), .chan_i(chan), .comp_o(comp));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Source clocks never stop, so no conversion is cut short
    always @(posedge sys_clk) src_cnt <= src_cnt + 4'h1;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [5:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // One cycle, noting power enables; fast conversions may end before wait_done
    task automatic watch();
        @(posedge sys_clk);
        #1;
        if (core_en === 1'b1) saw_core = 1'b1;
        if (osc_en === 1'b1) saw_osc = 1'b1;
    endtask

    task automatic wait_done();
        cyc = 0;
        repeat (3) watch();
        while (busy !== 1'b0 && cyc < 20000) begin
            watch();
            cyc++;
        end
        chk(busy, 1'b0);
    endtask

    // One single conversion, software or timer triggered
    task automatic run_single(input int src, dv, sh, inv, sample_pulse_mode_sel, slot, ch, dbl, input logic [11:0] val);
        logic [15:0] v;
        i_ana.level[ch] = val;
        wr_reg(6'h00, 16'h0004); // Disarm before every run, software or timer triggered
        wr_reg(6'(6'h10 + slot), 16'(8'h80 | ((ch % 8) << 4) | ch));
        wr_reg(6'h01, 16'((slot << 12) | (sh << 9) | (inv << 8) | (sample_pulse_mode_sel << 7) | (dv << 4) | (src << 2)));
        tmr <= {3{inv[0]}};
        saw_core = 1'b0;
        saw_osc = 1'b0;
        wr_reg(6'h00, (sh == 0) ? 16'h0017 : 16'h0015);
        if (sh != 0) begin
            @(posedge sys_clk);
            tmr[sh - 1] <= ~inv[0];
            repeat (300) watch();
            if (sample_pulse_mode_sel == 0) chk(sample, 1'b1);
            tmr <= {3{inv[0]}};
            if (dbl != 0) begin
                repeat (20) watch();
                tmr[sh - 1] <= ~inv[0];
            end
        end
        wait_done();
        chk(saw_core, 1'b1);
        chk(saw_osc, 1'(src == 3));
        chk({core_en, ref_en}, 2'b01);
        chk(chan, 16'(ch));
        chk(ref_sel, 16'(ch % 8));
        exp_mem[slot] = val;
        exp_flags[slot] = 1'b1;
        rd_reg(6'h02, v);
        chk(v, exp_flags);
        rd_reg(6'(6'h20 + slot), v);
        chk(v, 16'(exp_mem[slot]));
        exp_flags[slot] = 1'b0;
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end
        else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        addr = 6'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        tmr = 3'b000;
        src_cnt = 4'h0;
        n_fail = 0;
        checked = 0;
        exp_flags = 16'h0000;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            rd_reg(6'(a), d);
            chk(d, 16'h0000);
        end
        rd_reg(6'h3F, d);
        chk(d, 16'h0000);
        $display("test reset done");

        wr_reg(6'h00, 16'h000C);
        chk({ref_en, ref_high}, 2'b11);
        wr_reg(6'h00, 16'h0004);
        chk({ref_en, ref_high}, 2'b10);
        d = 16'(rnd() & 32'hFF);
        wr_reg(6'h04, d);
        chk(pins, d[7:0]);
        $display("test reference and pins done");

        for (int i = 0; i < 8; i++) begin
            r = rnd();
            shs = (i < 4) ? 0 : (i % 3) + 1;
            // Software start bit only rises uninverted; it clears when conversion begins
            run_single(i % 4, (i == 7) ? 7 : r[2:0], shs, (shs == 0) ? 0 : r[3], (shs == 0 || i == 7) ? 1 : r[4], r[11:8],
                r[15:12], i == 7, (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : r[27:16]);
        end
        rd_reg(6'h03, d);
        chk(d[2], 1'b1);
        wr_reg(6'h03, 16'h0006);
        $display("test single conversions done");

        run_single(0, 0, 0, 0, 1, 5, 5, 0, 12'h5A5);
        for (int k = 0; k < 2; k++) begin
            wr_reg(6'h00, 16'h0017);
            wait_done();
        end
        rd_reg(6'h03, d);
        chk(d[2:1], 2'b01);
        wr_reg(6'h01, 16'hFFFF);
        rd_reg(6'h01, d);
        chk(d, 16'h5080);
        wr_reg(6'h15, 16'h00FF);
        rd_reg(6'h15, d);
        chk(d, 16'h00D5);
        $display("test overrun and lock done");

        for (int m = 1; m < 4; m++) begin
            wr_reg(6'h00, 16'h0004);
            wr_reg(6'h03, 16'h0006);
            wr_reg(6'h02, 16'h0000);
            for (int k = 0; k < 4; k++) begin
                i_ana.level[k] = 12'(rnd());
                wr_reg(6'(16 + (k + 14) % 16), 16'((k >= 2) ? (8'h80 | k) : k));
            end
            wr_reg(6'h01, 16'(16'hE080 | m));
            wr_reg(6'h00, 16'h0037);
            if (m > 1) begin
                repeat (2000) @(posedge sys_clk);
                chk(busy, 1'b1);
                wr_reg(6'h00, 16'h0004);
            end
            wait_done();
            if (m == 2) chk(1'(cyc < 100), 1'b1);
            rd_reg(6'h02, d);
            chk(d, (m == 2) ? 16'h4000 : 16'hC001);
            for (int k = 0; k < ((m == 2) ? 1 : 3); k++) begin
                rd_reg(6'(32 + (k + 14) % 16), d);
                chk(d, 16'(i_ana.level[k]));
            end
        end
        $display("test sequence modes done");
        results();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
endmodule

`default_nettype wire
